//--- design/etrg_reset_gen.sv
// event triggered reset generator with register port and pin override
`timescale 1ns/100ps

// Notes on behaviour
// - Bit 7 of the second select register picks whether the second event counts when active or inactive.
// - Bit 7 of the third select register picks whether the third event counts when active or inactive.
// - The low seven bits of the second and third select registers name the event that slot watches.
// - The reset output is active low when the polarity bit is 0 and active high when it is 1.
// - With the pin override enabled the external reset pin is ORed into the reset output.
// - A reset pulse is produced only when every configured event holds together for the full hold time.
// - Hold codes 0000 to 0111 mean immediate, 1.0, 1.5, 2.0, 2.5, 3.0, 3.5 and 4.0 seconds.
// - Hold codes 1000, 1001, 1011, 1101, 1111 mean 5, 6, 8, 10, 12 seconds; 1010, 1100, 1110 are undefined.
// - The width field gives pulses of 500 us, 1 ms, 2 ms or 10 ms.
// - A slot whose event code is zero is left out of the simultaneity check.
// - Level 0 lets a released key qualify and level 1 a pressed one; input and logic events only use level 1.
// - There are three slots, the first in its own select register of the same layout.
module etrg_reset_gen #(
	parameter int unsigned HOLD_UNIT_CYC = etrg_pkg::HOLD_UNIT_CYC, // cycles per half second of hold
	parameter int unsigned PULSE_UNIT_CYC = etrg_pkg::PULSE_UNIT_CYC // cycles per 500 us of pulse
) (
	input wire logic i_clk, // system clock
	input wire logic i_resetn, // async reset, active low
	input wire logic i_reg_wr, // register write strobe
	input wire logic i_reg_rd, // register read strobe
	input wire logic [7:0] i_reg_addr, // register offset
	input wire logic [7:0] i_reg_wdata, // register write data
	input wire logic [127:0] i_event_state, // live level of each internal event by code
	input wire logic i_ext_rst_n, // external reset pin, active low
	output logic [7:0] o_reg_rdata, // register read data
	output logic o_reset_out // reset output, polarity per config
);

	// slot registers: index 0 first, 1 second, 2 third
	logic [7:0] sel_r [3];
	logic [7:0] sel_nxt [3];
	logic [7:0] cfg_r;
	logic [7:0] cfg_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	etrg_pkg::etrg_state_t state_r;
	etrg_pkg::etrg_state_t state_nxt;
	logic [31:0] cnt_r;
	logic [31:0] cnt_nxt;
	logic act_r;
	logic act_nxt;
	logic out_r;
	logic out_nxt;
	logic pin_meta_r;
	logic pin_sync_r;
	logic [2:0] slot_ok;
	logic any_used;
	logic cond;
	logic hold_ok;
	logic [31:0] hold_tgt;
	logic [31:0] pulse_tgt;

	// key codes accept both levels, others only the active one
	function automatic logic is_key(input logic [6:0] code);
		is_key = (code != 7'h00) && (code <= etrg_pkg::LAST_KEY_CODE);
	endfunction

	// one slot qualifies when unused, when its event is active at level 1, or when its key code is inactive at level 0
	function automatic logic slot_qual(input logic [7:0] sel, input logic [127:0] ev);
		logic [6:0] code;
		logic lvl;
		code = sel[etrg_pkg::SEL_CODE_MSB:etrg_pkg::SEL_CODE_LSB];
		lvl = sel[etrg_pkg::SEL_LEVEL_BIT];
		if (code == 7'h00) begin
			slot_qual = 1'b1;
		end else if (lvl) begin
			slot_qual = ev[code];
		end else begin
			slot_qual = is_key(code) && !ev[code];
		end
	endfunction

	// hold code to half second units
	function automatic logic [4:0] hold_units(input logic [3:0] code);
		case (code)
			4'h0: hold_units = 5'h00;
			4'h1: hold_units = 5'h02;
			4'h2: hold_units = 5'h03;
			4'h3: hold_units = 5'h04;
			4'h4: hold_units = 5'h05;
			4'h5: hold_units = 5'h06;
			4'h6: hold_units = 5'h07;
			4'h7: hold_units = 5'h08;
			4'h8: hold_units = 5'h0a;
			4'h9: hold_units = 5'h0c;
			4'hb: hold_units = 5'h10;
			4'hd: hold_units = 5'h14;
			4'hf: hold_units = 5'h18;
			default: hold_units = 5'h00;
		endcase
	endfunction

	// width code to 500 us units
	function automatic logic [4:0] width_units(input logic [1:0] code);
		case (code)
			2'h0: width_units = 5'h01;
			2'h1: width_units = 5'h02;
			2'h2: width_units = 5'h04;
			default: width_units = 5'h14;
		endcase
	endfunction

	// trigger condition and targets
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			slot_ok[i] = slot_qual(sel_r[i], i_event_state);
		end
		any_used = 1'b0;
		for (int i = 0; i < 3; i++) begin
			any_used = any_used | (sel_r[i][etrg_pkg::SEL_CODE_MSB:etrg_pkg::SEL_CODE_LSB] != 7'h00);
		end
		cond = any_used && (&slot_ok);
		hold_ok = !(cfg_r[etrg_pkg::CFG_HOLD_MSB:etrg_pkg::CFG_HOLD_LSB] inside {4'ha, 4'hc, 4'he});
		hold_tgt = 32'(hold_units(cfg_r[etrg_pkg::CFG_HOLD_MSB:etrg_pkg::CFG_HOLD_LSB]) * HOLD_UNIT_CYC);
		pulse_tgt = 32'(width_units(cfg_r[etrg_pkg::CFG_WIDTH_MSB:etrg_pkg::CFG_WIDTH_LSB]) * PULSE_UNIT_CYC);
	end

	// register writes and registered reads
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			sel_nxt[i] = sel_r[i];
		end
		cfg_nxt = cfg_r;
		rdata_nxt = rdata_r;
		if (i_reg_wr) begin
			if (i_reg_addr == etrg_pkg::ADDR_FIRST_SEL) begin
				sel_nxt[0] = i_reg_wdata;
			end else if (i_reg_addr == etrg_pkg::ADDR_SECOND_SEL) begin
				sel_nxt[1] = i_reg_wdata;
			end else if (i_reg_addr == etrg_pkg::ADDR_THIRD_SEL) begin
				sel_nxt[2] = i_reg_wdata;
			end else if (i_reg_addr == etrg_pkg::ADDR_CONFIG) begin
				cfg_nxt = i_reg_wdata;
			end
		end
		if (i_reg_rd) begin
			if (i_reg_addr == etrg_pkg::ADDR_FIRST_SEL) begin
				rdata_nxt = sel_r[0];
			end else if (i_reg_addr == etrg_pkg::ADDR_SECOND_SEL) begin
				rdata_nxt = sel_r[1];
			end else if (i_reg_addr == etrg_pkg::ADDR_THIRD_SEL) begin
				rdata_nxt = sel_r[2];
			end else if (i_reg_addr == etrg_pkg::ADDR_CONFIG) begin
				rdata_nxt = cfg_r;
			end else begin
				rdata_nxt = 8'h00;
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			for (int i = 0; i < 3; i++) begin
				sel_r[i] <= etrg_pkg::SEL_RESET;
			end
			cfg_r <= etrg_pkg::CONFIG_RESET;
			rdata_r <= 8'h00;
		end else begin
			for (int i = 0; i < 3; i++) begin
				sel_r[i] <= sel_nxt[i];
			end
			cfg_r <= cfg_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	assign o_reg_rdata = rdata_r;

	// hold and pulse sequencer
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		case (state_r)
			etrg_pkg::ST_IDLE: begin
				cnt_nxt = 32'h0000_0000;
				if (cond && hold_ok) begin
					if (hold_tgt == 32'h0000_0000) begin
						state_nxt = etrg_pkg::ST_PULSE;
					end else begin
						state_nxt = etrg_pkg::ST_HOLD;
						cnt_nxt = 32'h0000_0001;
					end
				end
			end
			etrg_pkg::ST_HOLD: begin
				if (!cond || !hold_ok) begin
					state_nxt = etrg_pkg::ST_IDLE;
					cnt_nxt = 32'h0000_0000;
				end else if (cnt_r >= hold_tgt) begin
					state_nxt = etrg_pkg::ST_PULSE;
					cnt_nxt = 32'h0000_0000;
				end else begin
					cnt_nxt = cnt_r + 32'h0000_0001;
				end
			end
			etrg_pkg::ST_PULSE: begin
				if (cnt_r >= pulse_tgt - 32'h0000_0001) begin
					state_nxt = etrg_pkg::ST_REARM;
					cnt_nxt = 32'h0000_0000;
				end else begin
					cnt_nxt = cnt_r + 32'h0000_0001;
				end
			end
			default: begin
				cnt_nxt = 32'h0000_0000;
				if (!cond) begin
					state_nxt = etrg_pkg::ST_IDLE;
				end
			end
		endcase
	end

	// output level: pulse or overriding pin, then polarity
	always_comb begin
		act_nxt = (state_nxt == etrg_pkg::ST_PULSE) || (cfg_r[etrg_pkg::CFG_PIN_OVERRIDE_BIT] && !pin_sync_r);
		out_nxt = cfg_r[etrg_pkg::CFG_POLARITY_BIT] ? act_nxt : !act_nxt;
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_r <= etrg_pkg::ST_IDLE;
			cnt_r <= 32'h0000_0000;
			act_r <= 1'b0;
			out_r <= 1'b1;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			act_r <= act_nxt;
			out_r <= out_nxt;
		end
	end

	// two stage synchroniser for the external pin, idle high
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pin_meta_r <= 1'b1;
			pin_sync_r <= 1'b1;
		end else begin
			pin_meta_r <= i_ext_rst_n;
			pin_sync_r <= pin_meta_r;
		end
	end

	assign o_reset_out = out_r;

	// checks on the sequencer and output
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	property p_polarity;
		o_reset_out == ($past(cfg_r[etrg_pkg::CFG_POLARITY_BIT]) ? act_r : !act_r);
	endproperty
	a_polarity: assert property (p_polarity) else $error("reset output polarity wrong");

	property p_pin_override;
		(cfg_r[etrg_pkg::CFG_PIN_OVERRIDE_BIT] && !pin_sync_r) |=> act_r;
	endproperty
	a_pin_override: assert property (p_pin_override) else $error("pin override not seen");

	property p_pulse_cause;
		(state_r != etrg_pkg::ST_PULSE) ##1 (state_r == etrg_pkg::ST_PULSE) |-> $past(cond) && $past(hold_ok);
	endproperty
	a_pulse_cause: assert property (p_pulse_cause) else $error("pulse without trigger");

	property p_dropout;
		(state_r == etrg_pkg::ST_HOLD && !cond) |=> (state_r == etrg_pkg::ST_IDLE && cnt_r == 32'h0000_0000);
	endproperty
	a_dropout: assert property (p_dropout) else $error("hold not restarted");

	property p_no_slots;
		(sel_r[0][6:0] == 7'h00 && sel_r[1][6:0] == 7'h00 && sel_r[2][6:0] == 7'h00) |-> !cond;
	endproperty
	a_no_slots: assert property (p_no_slots) else $error("trigger with no slot");

	property p_hold_one_sec;
		(cfg_r[5:2] == 4'h1) |-> (hold_tgt == 32'(2 * HOLD_UNIT_CYC));
	endproperty
	a_hold_one_sec: assert property (p_hold_one_sec) else $error("hold decode wrong");

	property p_hold_undef;
		(cfg_r[5:2] == 4'hc && state_r == etrg_pkg::ST_IDLE) |=> (state_r == etrg_pkg::ST_IDLE);
	endproperty
	a_hold_undef: assert property (p_hold_undef) else $error("undefined hold code armed");

	property p_pulse_len;
		(state_r == etrg_pkg::ST_PULSE) ##1 (state_r != etrg_pkg::ST_PULSE) |->
			$past(cnt_r) >= $past(pulse_tgt) - 32'h0000_0001;
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("pulse ended early");

	property p_release_level;
		(sel_r[1][6:0] != 7'h00 && !sel_r[1][7] && !is_key(sel_r[1][6:0])) |-> !cond;
	endproperty
	a_release_level: assert property (p_release_level) else $error("release of non key qualified");

	property p_third_slot;
		(sel_r[2][6:0] != 7'h00 && sel_r[2][7]) |-> (slot_ok[2] == i_event_state[sel_r[2][6:0]]);
	endproperty
	a_third_slot: assert property (p_third_slot) else $error("third slot code ignored");

	property p_first_slot;
		(sel_r[0][6:0] != 7'h00 && !slot_ok[0]) |-> !cond;
	endproperty
	a_first_slot: assert property (p_first_slot) else $error("first slot ignored");

	c_hold_to_pulse: cover property ((state_r == etrg_pkg::ST_HOLD) ##1 (state_r == etrg_pkg::ST_PULSE));
	c_immediate: cover property ((state_r == etrg_pkg::ST_IDLE) ##1 (state_r == etrg_pkg::ST_PULSE));
	c_dropout: cover property ((state_r == etrg_pkg::ST_HOLD) ##1 (state_r == etrg_pkg::ST_IDLE));
	c_override: cover property (cfg_r[6] && !pin_sync_r && state_r == etrg_pkg::ST_IDLE);

endmodule

//--- include/etrg_pkg.sv
// constants and types shared by the event triggered reset generator
package etrg_pkg;
	// register offsets
	localparam logic [7:0] ADDR_FIRST_SEL = 8'h2b;
	localparam logic [7:0] ADDR_SECOND_SEL = 8'h2c;
	localparam logic [7:0] ADDR_THIRD_SEL = 8'h2d;
	localparam logic [7:0] ADDR_CONFIG = 8'h2e;
	// values after reset
	localparam logic [7:0] SEL_RESET = 8'h00;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	// field positions in the trigger select registers
	localparam int SEL_LEVEL_BIT = 7;
	localparam int SEL_CODE_MSB = 6;
	localparam int SEL_CODE_LSB = 0;
	// field positions in the config register
	localparam int CFG_POLARITY_BIT = 7;
	localparam int CFG_PIN_OVERRIDE_BIT = 6;
	localparam int CFG_HOLD_MSB = 5;
	localparam int CFG_HOLD_LSB = 2;
	localparam int CFG_WIDTH_MSB = 1;
	localparam int CFG_WIDTH_LSB = 0;
	// highest event code that names a key; above it are input and logic events
	localparam logic [6:0] LAST_KEY_CODE = 7'h19;
	// clock rate and time bases
	localparam int CLK_FREQ_MHZ = 100;
	localparam int HOLD_UNIT_MS = 500;
	localparam int PULSE_UNIT_US = 500;
	localparam int HOLD_UNIT_CYC = CLK_FREQ_MHZ * 1000 * HOLD_UNIT_MS;
	localparam int PULSE_UNIT_CYC = CLK_FREQ_MHZ * PULSE_UNIT_US;
	// sequencer states
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_HOLD,
		ST_PULSE,
		ST_REARM
	} etrg_state_t;
endpackage

//--- test/etrg_host_model.sv
// host reset input model that measures reset pulses
`timescale 1ns/100ps
module etrg_host_model (
	input wire logic i_clk, // system clock
	input wire logic i_rst_line, // reset line from generator
	input wire logic i_pol, // active level host expects
	output logic o_in_reset, // host held in reset
	output int o_last_len, // cycles of last pulse
	output int o_pulses // pulses seen
);
	int len = 0;
	int last = 0;
	int seen = 0;
	// host sees reset when the line sits at the active level
	assign o_in_reset = (i_rst_line === i_pol);
	assign o_last_len = last;
	assign o_pulses = seen;
	// count pulses and their length in cycles
	always @(posedge i_clk) begin
		if (o_in_reset) begin
			if (len == 0)
				seen <= seen + 1;
			len <= len + 1;
		end else if (len != 0) begin
			last <= len;
			len <= 0;
		end
	end
endmodule

//--- test/etrg_reset_gen_test.sv
// self-checking bench for the event triggered reset generator
`timescale 1ns/100ps
module etrg_reset_gen_test;
	localparam int HU = 10;
	localparam int PU = 4;
	logic clk = 0, resetn = 0, wr = 0, rd = 0, ext_n = 1, pol = 0, act, rst_out;
	logic [7:0] addr = 0, wdata = 0, rdata;
	logic [127:0] ev = 0;
	logic [31:0] seed = 32'h0000_8691;
	int last_len, pulses, n, fail_count = 0, cmp_count = 0;
	// free running clock
	always #5 clk = ~clk;
	etrg_reset_gen #(.HOLD_UNIT_CYC(HU), .PULSE_UNIT_CYC(PU)) u_dut (.i_clk(clk), .i_resetn(resetn),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .i_event_state(ev),
		.i_ext_rst_n(ext_n), .o_reg_rdata(rdata), .o_reset_out(rst_out));
	etrg_host_model u_host (.i_clk(clk), .i_rst_line(rst_out), .i_pol(pol), .o_in_reset(act),
		.o_last_len(last_len), .o_pulses(pulses));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// hold length in cycles, -1 where the code never fires
	function automatic int hold_cyc(input logic [3:0] c);
		case (c)
			4'h0: return 0;
			4'h8: return 10 * HU;
			4'h9: return 12 * HU;
			4'hb: return 16 * HU;
			4'hd: return 20 * HU;
			4'hf: return 24 * HU;
			4'ha, 4'hc, 4'he: return -1;
			default: return (int'(c) + 1) * HU;
		endcase
	endfunction
	function automatic int pulse_cyc(input logic [1:0] w);
		return PU * (w == 0 ? 1 : w == 1 ? 2 : w == 2 ? 4 : 20);
	endfunction
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", name, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		wr = 1;
		addr = a;
		wdata = d;
		@(negedge clk);
		wr = 0;
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(negedge clk);
		rd = 1;
		addr = a;
		@(negedge clk);
		rd = 0;
		d = rdata;
	endtask
	// cycles until the host enters reset, 0 if it never does
	task automatic fire(input int lim);
		n = 0;
		while (act !== 1'b1 && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (act !== 1'b1)
			n = 0;
	endtask
	task automatic settle();
		repeat (400) if (act === 1'b1) @(posedge clk);
		repeat (3) @(negedge clk);
	endtask
	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// watchdog against a hang
	initial begin
		repeat (60000) @(posedge clk);
		fail_count++;
		test_done();
	end
	// main sequence
	initial begin
		logic [7:0] d;
		int p;
		repeat (10) @(negedge clk);
		chk("reset out", 1, rst_out);
		resetn = 1;
		for (int a = 8'h2b; a <= 8'h2f; a++) begin
			rd_reg(8'(a), d);
			chk("reset value", 0, d);
			seed = xs(seed);
			wr_reg(8'(a), seed[7:0]);
			rd_reg(8'(a), d);
			chk("read back", a == 8'h2f ? 8'h00 : seed[7:0], d);
		end
		for (int a = 8'h2b; a <= 8'h2e; a++) wr_reg(8'(a), 8'h00);
		repeat (400) @(negedge clk);
		$display("register test done");
		wr_reg(8'h2b, 8'h85);
		for (int h = 0; h < 16; h++) begin
			seed = xs(seed);
			wr_reg(8'h2e, {h[0], 1'b0, h[3:0], seed[1:0]});
			pol = h[0];
			repeat (2) @(negedge clk);
			chk("idle level", !h[0], rst_out);
			p = pulses;
			ev[5] = 1;
			fire(400);
			chk("hold cycles", hold_cyc(h[3:0]) + 1, n);
			settle();
			if (n != 0)
				chk("pulse width", pulse_cyc(seed[1:0]), last_len);
			repeat (30) @(negedge clk);
			chk("one pulse", p + (n != 0), pulses);
			ev[5] = 0;
		end
		$display("hold and width test done");
		wr_reg(8'h2e, 8'h04);
		pol = 0;
		repeat (2) @(negedge clk);
		ev[5] = 1;
		repeat (10) @(negedge clk);
		ev[5] = 0;
		@(negedge clk);
		ev[5] = 1;
		fire(400);
		chk("restart", 2 * HU + 1, n);
		settle();
		ev = 0;
		wr_reg(8'h2c, 8'h9a);
		wr_reg(8'h2d, 8'h03);
		wr_reg(8'h2e, 8'h00);
		ev[5] = 1;
		ev[26] = 1;
		fire(50);
		chk("all slots", 1, n);
		settle();
		ev[3] = 1;
		fire(50);
		chk("pressed key", 0, n);
		wr_reg(8'h2d, 8'h1b);
		fire(50);
		chk("release of input", 0, n);
		wr_reg(8'h2d, 8'h83);
		fire(50);
		chk("third slot press", 1, n);
		settle();
		ev[3] = 0;
		wr_reg(8'h2d, 8'h00);
		fire(50);
		chk("empty slot", 1, n > 0);
		settle();
		ev = 0;
		$display("slot test done");
		wr_reg(8'h2e, 8'h40);
		ext_n = 0;
		fire(10);
		chk("pin override", 1, n > 0);
		@(negedge clk);
		ext_n = 1;
		settle();
		wr_reg(8'h2e, 8'h00);
		ext_n = 0;
		fire(10);
		chk("pin ignored", 0, n);
		@(negedge clk);
		ext_n = 1;
		$display("override test done");
		test_done();
	end
endmodule
